// ### src/rsl_pkg.sv
// package: constants and types of the reset state and register lock block
package rsl_pkg;
  // timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int RST_HOLD_NS   = 100;
  localparam int RST_HOLD_CYC  = (RST_HOLD_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
  localparam int CNT_W         = 8;
  localparam logic [CNT_W-1:0] HOLD_LAST = CNT_W'(RST_HOLD_CYC - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO  = 8'h00;

  // core
  localparam logic [31:0] BOOT_ADDR = 32'h0000_0000;

  // key sequence defaults (values are arbitrary)
  localparam logic [7:0] KEY_FIRST_DEF  = 8'hA5;
  localparam logic [7:0] KEY_SECOND_DEF = 8'hF1;

  // lock groups
  localparam int LOCK_W          = 32;
  localparam int CLKRST_LOCK_BIT = 0;
  localparam logic [LOCK_W-1:0] PLOCK_RST = 32'h0000_0000;

  // reset sources beside power-on and supply monitor
  localparam int NUM_SRC  = 4;
  // modules that a reset may optionally reset
  localparam int NUM_MOD     = 5;
  localparam int MOD_CHGPUMP = 0;
  localparam int MOD_SERIAL  = 1;
  localparam int MOD_LCD     = 2;
  localparam int MOD_CAPCTR  = 3;
  localparam int MOD_RTC     = 4;

  // peripheral bus clocks
  localparam int NUM_APB          = 16;
  localparam int APB_WDT          = 0;
  localparam int APB_DMA_CROSSBAR = 1;
  localparam logic [NUM_APB-1:0] APB_RST_MASK = 16'h0003;

  typedef enum logic [1:0] {
    RSL_CLK_LPOSC = 2'h0,
    RSL_CLK_HFOSC = 2'h1,
    RSL_CLK_EXT   = 2'h2,
    RSL_CLK_PLL   = 2'h3
  } rsl_sysclk_t;

  typedef enum logic {
    RSL_WDT_LFOSC = 1'h0,
    RSL_WDT_LPOSC = 1'h1
  } rsl_wdtclk_t;

  typedef enum logic [1:0] {
    RSL_ST_RESET   = 2'b00,
    RSL_ST_RELEASE = 2'b01,
    RSL_ST_RUN     = 2'b11
  } rsl_state_t;

  typedef enum logic [1:0] {
    RSL_KS_LOCKED = 2'b00,
    RSL_KS_HALF   = 2'b01,
    RSL_KS_OPEN   = 2'b11
  } rsl_key_state_t;

  typedef struct packed {
    logic [NUM_MOD-1:0] mod_opt;
    logic [NUM_SRC-1:0] src_en;
  } rsl_cfg_t;
  localparam rsl_cfg_t CFG_RST = '0;

  typedef struct packed {
    logic force_latch_one;
    logic force_open_drain;
    logic pullup_en;
    logic rst_pin_o;
    logic rst_pin_oe;
  } rsl_pin_t;

  typedef struct packed {
    logic               ahb_flash_en;
    logic               ahb_ram_en;
    logic [NUM_APB-1:0] apb_en;
    rsl_sysclk_t        sysclk_sel;
    logic               wdt_en;
    rsl_wdtclk_t        wdt_clk;
  } rsl_clk_t;
endpackage : rsl_pkg

// ### src/rsl_key_seq.sv
// key sequence detector that opens the peripheral lock registers
`timescale 1ns/1ps
module rsl_key_seq
  import rsl_pkg::*;
#(
  parameter logic [7:0] KEY_FIRST  = KEY_FIRST_DEF,
  parameter logic [7:0] KEY_SECOND = KEY_SECOND_DEF
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       sys_rst,
  // key register write
  input  wire logic       key_wr,
  input  wire logic [7:0] key_wdata,
  // state
  output      logic       unlocked
);
  rsl_key_state_t ks_ff;
  rsl_key_state_t nxt_ks;

  always_comb begin
    nxt_ks = ks_ff;
    if (sys_rst) begin
      nxt_ks = RSL_KS_LOCKED;
    end else if (key_wr) begin
      unique case (ks_ff)
        RSL_KS_LOCKED: begin
          nxt_ks = (key_wdata == KEY_FIRST) ? RSL_KS_HALF : RSL_KS_LOCKED;
        end
        // a wrong value restarts; it may itself be a new first key
        RSL_KS_HALF: begin
          if (key_wdata == KEY_SECOND) begin
            nxt_ks = RSL_KS_OPEN;
          end else if (key_wdata == KEY_FIRST) begin
            nxt_ks = RSL_KS_HALF;
          end else begin
            nxt_ks = RSL_KS_LOCKED;
          end
        end
        RSL_KS_OPEN: begin
          nxt_ks = RSL_KS_LOCKED;
        end
        default: begin
          nxt_ks = RSL_KS_LOCKED;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ks_ff <= RSL_KS_LOCKED;
    end else begin
      ks_ff <= nxt_ks;
    end
  end

  assign unlocked = (ks_ff == RSL_KS_OPEN);
endmodule : rsl_key_seq

// ### src/rsl_reset_lock.sv
// reset state sequencer with peripheral register lock and key
`timescale 1ns/1ps
module rsl_reset_lock
  import rsl_pkg::*;
#(
  parameter logic [7:0] KEY_FIRST  = KEY_FIRST_DEF,
  parameter logic [7:0] KEY_SECOND = KEY_SECOND_DEF
) (
  // clock and power-on reset
  input  wire logic               clk,
  input  wire logic               arst_n,
  // reset requests
  input  wire logic               por_req,
  input  wire logic               vbat_mon_req,
  input  wire logic [NUM_SRC-1:0] src_req,
  // reset source configuration
  input  wire logic               cfg_wr,
  input  wire rsl_cfg_t           cfg_wdata,
  output      rsl_cfg_t           cfg_rdata,
  // system clock, watchdog, pullup and peripheral clock controls
  input  wire logic               sysclk_wr,
  input  wire rsl_sysclk_t        sysclk_wdata,
  input  wire logic               wdt_wr,
  input  wire logic               wdt_en_wdata,
  input  wire rsl_wdtclk_t        wdt_clk_wdata,
  input  wire logic               pullup_wr,
  input  wire logic               pullup_wdata,
  input  wire logic               apb_wr,
  input  wire logic [NUM_APB-1:0] apb_wdata,
  // key and peripheral lock registers
  input  wire logic               key_wr,
  input  wire logic [7:0]         key_wdata,
  output      logic               key_unlocked,
  input  wire logic               plock_wr,
  input  wire logic [LOCK_W-1:0]  plock_wdata,
  output      logic [LOCK_W-1:0]  plock_rdata,
  // per-group peripheral access
  input  wire logic [LOCK_W-1:0]  periph_wr_req,
  output      logic [LOCK_W-1:0]  periph_wr_en,
  input  wire logic [LOCK_W-1:0]  periph_rd_req,
  output      logic [LOCK_W-1:0]  periph_rd_en,
  // core
  output      logic               core_halt,
  output      logic               pc_load,
  output      logic [31:0]        pc_value,
  // system side
  output      logic               sys_rst,
  output      logic               por_only_rst,
  output      logic               irq_disable,
  output      logic               timer_disable,
  output      logic               ram_preserve,
  output      logic [NUM_MOD-1:0] mod_rst,
  output      rsl_pin_t           pin_ctl,
  output      rsl_clk_t           clk_ctl,
  output      logic [1:0]         last_cause
);
  // sequencer state
  rsl_state_t       st_ff;
  rsl_state_t       nxt_st;
  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] nxt_cnt;
  logic [1:0]       cause_ff;
  logic [1:0]       nxt_cause;
  logic             pin_cause;
  logic             any_req;
  logic             in_rst;
  logic             running;

  // configuration and control state
  rsl_cfg_t           cfg_ff;
  rsl_cfg_t           nxt_cfg;
  logic [LOCK_W-1:0]  plock_ff;
  logic [LOCK_W-1:0]  nxt_plock;
  rsl_clk_t           clk_ff;
  rsl_clk_t           nxt_clk;
  logic               pullup_ff;
  logic               nxt_pullup;
  logic               pc_load_ff;
  logic               nxt_pc_load;

  // cause bit 0: power-on, bit 1: supply monitor; either one drives the reset pin
  assign pin_cause = |cause_ff;
  assign any_req   = por_req | vbat_mon_req | (|(src_req & cfg_ff.src_en));
  assign in_rst    = (st_ff == RSL_ST_RESET);
  assign running   = (st_ff == RSL_ST_RUN);

  always_comb begin
    nxt_st    = st_ff;
    nxt_cnt   = cnt_ff;
    nxt_cause = cause_ff;
    if (any_req) begin
      nxt_st  = RSL_ST_RESET;
      nxt_cnt = CNT_ZERO;
      if (!in_rst) begin
        nxt_cause = {vbat_mon_req, por_req};
      end else begin
        nxt_cause = cause_ff | {vbat_mon_req, por_req};
      end
    end else begin
      unique case (st_ff)
        RSL_ST_RESET: begin
          if (cnt_ff == HOLD_LAST) begin
            nxt_st = RSL_ST_RELEASE;
          end else begin
            nxt_cnt = cnt_ff + 8'h01;
          end
        end
        RSL_ST_RELEASE: begin
          nxt_st = RSL_ST_RUN;
        end
        RSL_ST_RUN: begin
          nxt_st = RSL_ST_RUN;
        end
        default: begin
          nxt_st = RSL_ST_RESET;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_ff    <= RSL_ST_RESET;
      cnt_ff   <= CNT_ZERO;
      cause_ff <= 2'h1;
    end else begin
      st_ff    <= nxt_st;
      cnt_ff   <= nxt_cnt;
      cause_ff <= nxt_cause;
    end
  end

  // register writes: defaults while in reset, firmware writes when running
  always_comb begin
    nxt_cfg     = cfg_ff;
    nxt_plock   = plock_ff;
    nxt_clk     = clk_ff;
    nxt_pullup  = pullup_ff;
    nxt_pc_load = (st_ff == RSL_ST_RELEASE) && !any_req;
    if (in_rst) begin
      nxt_cfg              = CFG_RST;
      nxt_plock            = PLOCK_RST;
      nxt_pullup           = 1'b1;
      nxt_clk.ahb_flash_en = 1'b1;
      nxt_clk.ahb_ram_en   = 1'b1;
      nxt_clk.apb_en       = APB_RST_MASK;
      nxt_clk.sysclk_sel   = RSL_CLK_LPOSC;
      nxt_clk.wdt_en       = 1'b1;
      nxt_clk.wdt_clk      = RSL_WDT_LFOSC;
    end else if (running) begin
      if (cfg_wr && !plock_ff[CLKRST_LOCK_BIT]) begin
        nxt_cfg = cfg_wdata;
      end
      if (plock_wr && key_unlocked) begin
        nxt_plock = plock_wdata;
      end
      if (sysclk_wr) begin
        nxt_clk.sysclk_sel = sysclk_wdata;
      end
      if (wdt_wr) begin
        nxt_clk.wdt_en  = wdt_en_wdata;
        nxt_clk.wdt_clk = wdt_clk_wdata;
      end
      if (apb_wr) begin
        nxt_clk.apb_en = apb_wdata;
      end
      if (pullup_wr) begin
        nxt_pullup = pullup_wdata;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_ff     <= CFG_RST;
      plock_ff   <= PLOCK_RST;
      clk_ff     <= '{ahb_flash_en: 1'b1, ahb_ram_en: 1'b1,
                      apb_en: APB_RST_MASK, sysclk_sel: RSL_CLK_LPOSC,
                      wdt_en: 1'b1, wdt_clk: RSL_WDT_LFOSC};
      pullup_ff  <= 1'b1;
      pc_load_ff <= 1'b0;
    end else begin
      cfg_ff     <= nxt_cfg;
      plock_ff   <= nxt_plock;
      clk_ff     <= nxt_clk;
      pullup_ff  <= nxt_pullup;
      pc_load_ff <= nxt_pc_load;
    end
  end

  rsl_key_seq #(
    .KEY_FIRST  (KEY_FIRST),
    .KEY_SECOND (KEY_SECOND)
  ) u_key (
    .clk       (clk),
    .arst_n    (arst_n),
    .sys_rst   (in_rst),
    .key_wr    (key_wr && running),
    .key_wdata (key_wdata),
    .unlocked  (key_unlocked)
  );

  // one gate per lock group
  genvar g;
  generate
    for (g = 0; g < LOCK_W; g++) begin : g_lock
      assign periph_wr_en[g] = periph_wr_req[g]
                               && !plock_ff[g];
      assign periph_rd_en[g] = periph_rd_req[g];
    end
  endgenerate

  assign plock_rdata   = plock_ff;
  assign cfg_rdata     = cfg_ff;
  assign core_halt     = !running;
  assign pc_load       = pc_load_ff;
  assign pc_value      = BOOT_ADDR;
  assign sys_rst       = in_rst;
  // power-on-only bits reset while in reset with the power-on cause bit set
  assign por_only_rst  = in_rst && cause_ff[0];
  assign irq_disable   = !running;
  assign timer_disable = !running;
  // no path here clears or writes RAM during reset
  assign ram_preserve  = 1'b1;
  assign mod_rst       = in_rst ? cfg_ff.mod_opt : '0;
  assign last_cause    = cause_ff;
  assign clk_ctl       = clk_ff;
  assign pin_ctl.force_latch_one  = !running;
  assign pin_ctl.force_open_drain = !running;
  assign pin_ctl.pullup_en        = pullup_ff;
  assign pin_ctl.rst_pin_o        = 1'b0;
  assign pin_ctl.rst_pin_oe       = !running && pin_cause;

  // checks
  property p_halt;
    @(posedge clk) disable iff (!arst_n)
      any_req |=> core_halt && irq_disable && timer_disable;
  endproperty
  a_halt: assert property (p_halt)
    else $error("core not halted after reset request");

  property p_pin;
    @(posedge clk) disable iff (!arst_n)
      (por_req || vbat_mon_req) |=> pin_ctl.rst_pin_oe && !pin_ctl.rst_pin_o;
  endproperty
  a_pin: assert property (p_pin)
    else $error("reset pin not driven low");

  property p_port;
    @(posedge clk) disable iff (!arst_n)
      in_rst ##1 in_rst |-> pin_ctl.pullup_en && pin_ctl.force_latch_one
                            && pin_ctl.force_open_drain;
  endproperty
  a_port: assert property (p_port)
    else $error("port state not forced in reset");

  property p_clk;
    @(posedge clk) disable iff (!arst_n)
      in_rst ##1 in_rst |-> clk_ctl.apb_en == APB_RST_MASK
                            && clk_ctl.ahb_flash_en && clk_ctl.ahb_ram_en;
  endproperty
  a_clk: assert property (p_clk)
    else $error("bus clocks wrong in reset");

  property p_exit;
    @(posedge clk) disable iff (!arst_n)
      $rose(running) |-> pc_load && pc_value == BOOT_ADDR
        && clk_ctl.sysclk_sel == RSL_CLK_LPOSC && clk_ctl.wdt_en
        && clk_ctl.wdt_clk == RSL_WDT_LFOSC;
  endproperty
  a_exit: assert property (p_exit)
    else $error("exit defaults not applied");

  property p_hold;
    @(posedge clk) disable iff (!arst_n)
      $rose(st_ff == RSL_ST_RELEASE) |-> $past(cnt_ff) == HOLD_LAST;
  endproperty
  a_hold: assert property (p_hold)
    else $error("reset released before hold time");

  property p_cfg_lock;
    @(posedge clk) disable iff (!arst_n)
      running && !any_req && cfg_wr && plock_ff[CLKRST_LOCK_BIT]
        |=> cfg_rdata == $past(cfg_rdata);
  endproperty
  a_cfg_lock: assert property (p_cfg_lock)
    else $error("locked reset config was written");

  property p_plock;
    @(posedge clk) disable iff (!arst_n)
      running && !any_req && plock_wr && !key_unlocked
        |=> plock_rdata == $past(plock_rdata);
  endproperty
  a_plock: assert property (p_plock)
    else $error("lock register changed without key");

  property p_relock;
    @(posedge clk) disable iff (!arst_n)
      running && !any_req && key_unlocked && key_wr |=> !key_unlocked;
  endproperty
  a_relock: assert property (p_relock)
    else $error("key write did not relock");

  property p_drop;
    @(posedge clk) disable iff (!arst_n)
      (periph_wr_en & plock_rdata) == '0;
  endproperty
  a_drop: assert property (p_drop)
    else $error("write passed to locked group");

  cv_exit: cover property (@(posedge clk) disable iff (!arst_n)
    in_rst ##1 (st_ff == RSL_ST_RELEASE) ##1 running);
  cv_unlock: cover property (@(posedge clk) disable iff (!arst_n)
    key_unlocked && plock_wr);
  cv_drop: cover property (@(posedge clk) disable iff (!arst_n)
    |(periph_wr_req & plock_rdata));
endmodule : rsl_reset_lock

// ### dv/rsl_src_model.sv
// reset source model: power-on, supply monitor and other requesters
`timescale 1ns/1ps
module rsl_src_model
  import rsl_pkg::*;
(
  // clock
  input  wire logic               clk,
  // reset requests
  output      logic               por_req,
  output      logic               vbat_mon_req,
  output      logic [NUM_SRC-1:0] src_req
);
  initial begin
    por_req      = 1'h0;
    vbat_mon_req = 1'h0;
    src_req      = '0;
  end

  // kind 0 power-on, 1 supply monitor, 2.. other sources; level held
  task automatic fire(input int kind, input int cyc);
    @(negedge clk);
    if (kind == 0) begin
      por_req = 1'h1;
    end else if (kind == 1) begin
      vbat_mon_req = 1'h1;
    end else begin
      src_req[kind-2] = 1'h1;
    end
    repeat (cyc) @(negedge clk);
    por_req      = 1'h0;
    vbat_mon_req = 1'h0;
    src_req      = '0;
  endtask : fire
endmodule : rsl_src_model

// ### dv/tb.sv
// testbench of the reset state and register lock block
`timescale 1ns/1ps
module tb
  import rsl_pkg::*;
;
  localparam logic [7:0] K1 = 8'h3C;
  localparam logic [7:0] K2 = 8'hC3;

  logic clk, arst_n, por_req, vbat_mon_req;
  logic [NUM_SRC-1:0] src_req;
  logic cfg_wr, sysclk_wr, wdt_wr, wdt_en_wdata, pullup_wr, pullup_wdata;
  logic apb_wr, key_wr, key_unlocked, plock_wr;
  rsl_cfg_t cfg_wdata, cfg_rdata;
  rsl_sysclk_t sysclk_wdata;
  rsl_wdtclk_t wdt_clk_wdata;
  logic [NUM_APB-1:0] apb_wdata;
  logic [7:0] key_wdata;
  logic [LOCK_W-1:0] plock_wdata, plock_rdata, periph_wr_req, periph_wr_en;
  logic [LOCK_W-1:0] periph_rd_req, periph_rd_en;
  logic core_halt, pc_load, sys_rst, por_only_rst, irq_disable;
  logic timer_disable, ram_preserve;
  logic [31:0] pc_value;
  logic [NUM_MOD-1:0] mod_rst;
  rsl_pin_t pin_ctl;
  rsl_clk_t clk_ctl;
  logic [1:0] last_cause;
  int bad_count, n_tests, cyc_cnt, n;
  logic [7:0] n_seq [3];

  rsl_reset_lock #(.KEY_FIRST(K1), .KEY_SECOND(K2)) u_rsl_reset_lock (
    .clk(clk), .arst_n(arst_n), .por_req(por_req),
    .vbat_mon_req(vbat_mon_req), .src_req(src_req), .cfg_wr(cfg_wr),
    .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .sysclk_wr(sysclk_wr),
    .sysclk_wdata(sysclk_wdata), .wdt_wr(wdt_wr),
    .wdt_en_wdata(wdt_en_wdata), .wdt_clk_wdata(wdt_clk_wdata),
    .pullup_wr(pullup_wr), .pullup_wdata(pullup_wdata), .apb_wr(apb_wr),
    .apb_wdata(apb_wdata), .key_wr(key_wr), .key_wdata(key_wdata),
    .key_unlocked(key_unlocked), .plock_wr(plock_wr),
    .plock_wdata(plock_wdata), .plock_rdata(plock_rdata),
    .periph_wr_req(periph_wr_req), .periph_wr_en(periph_wr_en),
    .periph_rd_req(periph_rd_req), .periph_rd_en(periph_rd_en),
    .core_halt(core_halt), .pc_load(pc_load), .pc_value(pc_value),
    .sys_rst(sys_rst), .por_only_rst(por_only_rst),
    .irq_disable(irq_disable), .timer_disable(timer_disable),
    .ram_preserve(ram_preserve), .mod_rst(mod_rst), .pin_ctl(pin_ctl),
    .clk_ctl(clk_ctl), .last_cause(last_cause)
  );

  rsl_src_model u_rsl_src_model (
    .clk(clk), .por_req(por_req), .vbat_mon_req(vbat_mon_req),
    .src_req(src_req)
  );

  always #2 clk = ~clk;

  task automatic chk(input string nm, input logic [31:0] exp,
                     input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : stop_test

  always @(posedge clk) begin
    cyc_cnt++;
    if (cyc_cnt == 3000) begin
      bad_count++;
      stop_test();
    end
  end

  // strobes: 0 cfg, 1 sysclk, 2 key, 3 plock, 4 wdt, 5 pullup, 6 apb
  task automatic wr(input int w);
    @(negedge clk);
    case (w)
      0: cfg_wr = 1'h1;
      1: sysclk_wr = 1'h1;
      2: key_wr = 1'h1;
      3: plock_wr = 1'h1;
      4: wdt_wr = 1'h1;
      5: pullup_wr = 1'h1;
      default: apb_wr = 1'h1;
    endcase
    @(negedge clk);
    {cfg_wr, sysclk_wr, key_wr, plock_wr, wdt_wr, pullup_wr, apb_wr} = '0;
  endtask : wr

  // run from request release to the first running cycle, then defaults
  task automatic run_chk(input logic [1:0] cause);
    n = 0;
    while (pc_load !== 1'h1 && n < 60) begin
      @(negedge clk);
      n++;
    end
    chk("release delay", 32'h1, 32'(n >= 24 && n <= 30));
    chk("core_halt", 32'h0, core_halt);
    chk("pc_value", 32'h0000_0000, pc_value);
    chk("irq_disable", 32'h0, irq_disable);
    chk("rst_pin_oe", 32'h0, pin_ctl.rst_pin_oe);
    chk("sysclk_sel", RSL_CLK_LPOSC, clk_ctl.sysclk_sel);
    chk("wdt_en", 32'h1, clk_ctl.wdt_en);
    chk("wdt_clk", RSL_WDT_LFOSC, clk_ctl.wdt_clk);
    chk("pullup_en", 32'h1, pin_ctl.pullup_en);
    chk("cfg_rdata", 32'h0, cfg_rdata);
    chk("last_cause", cause, last_cause);
    chk("mod_rst", 32'h0, mod_rst);
  endtask : run_chk

  task automatic sc_por;
    repeat (2) @(negedge clk);
    chk("core_halt", 32'h1, core_halt);
    chk("timer_disable", 32'h1, timer_disable);
    chk("latch_one", 32'h1, pin_ctl.force_latch_one);
    chk("open_drain", 32'h1, pin_ctl.force_open_drain);
    chk("pin oe", 32'h1, pin_ctl.rst_pin_oe);
    chk("pin out", 32'h0, pin_ctl.rst_pin_o);
    chk("ahb", 32'h3, {clk_ctl.ahb_flash_en, clk_ctl.ahb_ram_en});
    chk("apb_en", 32'h0003, clk_ctl.apb_en);
    chk("ram_preserve", 32'h1, ram_preserve);
    chk("por_only_rst", 32'h1, por_only_rst);
    arst_n = 1'h1;
    run_chk(2'h1);
  endtask : sc_por

  task automatic sc_src;
    cfg_wdata = '{mod_opt: 5'h15, src_en: 4'h1};
    wr(0);
    sysclk_wdata = RSL_CLK_HFOSC;
    wr(1);
    wdt_en_wdata = 1'h0;
    wdt_clk_wdata = RSL_WDT_LPOSC;
    wr(4);
    pullup_wdata = 1'h0;
    wr(5);
    apb_wdata = 16'hFFFF;
    wr(6);
    chk("apb_en", 32'hFFFF, clk_ctl.apb_en);
    chk("pullup_en", 32'h0, pin_ctl.pullup_en);
    chk("sysclk_sel", RSL_CLK_HFOSC, clk_ctl.sysclk_sel);
    chk("wdt", 32'h1, {clk_ctl.wdt_en, clk_ctl.wdt_clk});
    fork
      u_rsl_src_model.fire(3, 3);
      begin
        repeat (2) @(negedge clk);
        chk("disabled src", 32'h0, sys_rst);
      end
    join
    fork
      u_rsl_src_model.fire(2, 3);
      begin
        // module resets follow the options only until the config clears
        repeat (2) @(negedge clk);
        chk("sys_rst", 32'h1, sys_rst);
        chk("mod_rst", 32'h15, mod_rst);
        chk("irq_disable", 32'h1, irq_disable);
        chk("pin oe", 32'h0, pin_ctl.rst_pin_oe);
        @(negedge clk);
        chk("apb_en", 32'h0003, clk_ctl.apb_en);
        chk("pullup_en", 32'h1, pin_ctl.pullup_en);
      end
    join
    run_chk(2'h0);
  endtask : sc_src

  task automatic sc_mon;
    fork
      u_rsl_src_model.fire(1, 3);
      begin
        repeat (3) @(negedge clk);
        chk("pin oe", 32'h1, pin_ctl.rst_pin_oe);
        chk("pin out", 32'h0, pin_ctl.rst_pin_o);
        chk("por_only_rst", 32'h0, por_only_rst);
      end
    join
    run_chk(2'h2);
  endtask : sc_mon

  task automatic sc_key;
    cfg_wdata = '{mod_opt: 5'h00, src_en: 4'h2};
    wr(0);
    plock_wdata = 32'h0000_0021;
    wr(3);
    chk("plock locked", 32'h0, plock_rdata);
    chk("key state", 32'h0, key_unlocked);
    foreach (n_seq[i]) begin
      key_wdata = n_seq[i];
      wr(2);
    end
    chk("bad sequence", 32'h0, key_unlocked);
    key_wdata = K1;
    wr(2);
    wr(2);
    key_wdata = K2;
    wr(2);
    chk("key state", 32'h1, key_unlocked);
    wr(3);
    chk("plock", 32'h0000_0021, plock_rdata);
    cfg_wdata = '{mod_opt: 5'h1F, src_en: 4'hF};
    wr(0);
    chk("cfg locked", 32'h002, cfg_rdata);
    periph_wr_req = 32'hFFFF_FFFF;
    periph_rd_req = 32'hFFFF_FFFF;
    #1;
    chk("periph_wr_en", 32'hFFFF_FFDE, periph_wr_en);
    chk("periph_rd_en", 32'hFFFF_FFFF, periph_rd_en);
    wr(2);
    chk("relock", 32'h0, key_unlocked);
    plock_wdata = 32'h0;
    wr(3);
    chk("plock kept", 32'h0000_0021, plock_rdata);
  endtask : sc_key

  initial begin
    n_seq = '{K1, 8'h00, K2};
    clk = 1'h0;
    arst_n = 1'h0;
    {cfg_wr, sysclk_wr, key_wr, plock_wr, wdt_wr, pullup_wr, apb_wr} = '0;
    cfg_wdata = '0;
    sysclk_wdata = RSL_CLK_LPOSC;
    wdt_en_wdata = 1'h1;
    wdt_clk_wdata = RSL_WDT_LFOSC;
    pullup_wdata = 1'h1;
    apb_wdata = 16'h0000;
    key_wdata = 8'h00;
    plock_wdata = '0;
    periph_wr_req = '0;
    periph_rd_req = '0;
    sc_por();
    sc_src();
    sc_mon();
    sc_key();
    stop_test();
  end
endmodule : tb
